/* sscmd_date_chk.v */
// Calendar date validator for the system settings handler
`timescale 1ns/1ps
`default_nettype none
module sscmd_date_chk (
   // Date in BCD
   input wire [7:0] year_bcd,
   input wire [7:0] month_bcd,
   input wire [7:0] day_bcd,
   // Verdict
   output wire date_ok
);
   function [6:0] bcd2bin;
      input [7:0] v;
      begin
         bcd2bin = {3'h0, v[7:4]} * 7'h0A + {3'h0, v[3:0]};
      end
   endfunction

   function bcd_ok;
      input [7:0] v;
      begin
         bcd_ok = (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9);
      end
   endfunction

   wire [6:0] yr;
   wire [6:0] mo;
   wire [6:0] dy;
   reg [6:0] mdays;
   assign yr = bcd2bin(year_bcd);
   assign mo = bcd2bin(month_bcd);
   assign dy = bcd2bin(day_bcd);

   always @* begin
      case (mo)
         7'h02: mdays = (yr[1:0] == 2'h0) ? 7'h1D : 7'h1C;
         7'h04, 7'h06, 7'h09, 7'h0B: mdays = 7'h1E;
         default: mdays = 7'h1F;
      endcase
   end

   assign date_ok = bcd_ok(year_bcd) && bcd_ok(month_bcd) && bcd_ok(day_bcd) &&
                    (mo >= 7'h01) && (mo <= 7'h0C) && (dy >= 7'h01) && (dy <= mdays);
endmodule
`default_nettype wire

/* sscmd_host.sv */
// Host controller model speaking the register bus
`timescale 1ns/1ps
`default_nettype none
module sscmd_host (
   // Clock and answer
   input wire logic sys_clk,
   input wire logic pready,
   // Request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end
   // defined values unless a refusal is meant
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* sscmd_map.vh */
// Register map, field layout and timing constants of the system settings handler
`ifndef SSCMD_MAP_VH
`define SSCMD_MAP_VH

// Register byte offsets
`define SSCMD_CTRL 12'h000
`define SSCMD_EOMW 12'h004
`define SSCMD_TERM 12'h008
`define SSCMD_DATE 12'h00C
`define SSCMD_CMD 12'h010
`define SSCMD_STAT 12'h014
`define SSCMD_IRQ_ST 12'h018
`define SSCMD_IRQ_EN 12'h01C
`define SSCMD_IRQ_CLR 12'h020
`define SSCMD_STATE 12'h024

// Control field positions
`define SSCMD_F_BEEP 0
`define SSCMD_F_LFRQ_LO 1
`define SSCMD_F_LFRQ_HI 2
`define SSCMD_F_LOCK 3
`define SSCMD_F_HDR 4
`define SSCMD_F_MODE 5

// Mains frequency codes
`define SSCMD_LF_AUTO 2'h0
`define SSCMD_LF_50 2'h1
`define SSCMD_LF_60 2'h2

// Command register bits
`define SSCMD_C_RST 0
`define SSCMD_C_DATE 1

// Interrupt bits
`define SSCMD_I_ERR 0
`define SSCMD_I_DONE 1
`define SSCMD_I_REL 2

// Reset values
`define SSCMD_CTRL_RST 6'h00
`define SSCMD_EOMW_RST 7'h01
`define SSCMD_DATE_RST 24'h00_0101

// Pulse width limits in ms, timing
`define SSCMD_PW_MIN 7'h01
`define SSCMD_PW_MAX 7'h64
`define SSCMD_CLK_HZ 25000000
`define SSCMD_MS_HZ 1000
`define SSCMD_MS_CYC (`SSCMD_CLK_HZ / `SSCMD_MS_HZ)

// Terminator bytes
`define SSCMD_CR 8'h0D
`define SSCMD_LF 8'h0A

`endif

/* sscmd_properties.sv */
// Port assertions for the settings handler
`timescale 1ns/1ps
`default_nettype none
module sscmd_properties (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   // Events and panel
   input wire logic meas_end,
   input wire logic meas_start,
   input wire logic local_req,
   input wire logic local_grant,
   input wire logic panel_lock,
   input wire logic [1:0] mains_frequency_setting,
   input wire logic measure_done_strobe_n
);
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
   a_ready_one_wait: assert property (psel && penable && !pready |=> pready) else $error("no answer");
   a_error_with_ready: assert property (pslverr |-> pready) else $error("stray error");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000) else $error("data outside answer");
   a_strobe_on_end: assert property (meas_end ##1 !meas_start |=> !measure_done_strobe_n)
      else $error("strobe not asserted");
   a_strobe_cause: assert property ($fell(measure_done_strobe_n) |-> $past(meas_end, 2))
      else $error("strobe without end");
   a_lock_blocks: assert property (panel_lock |-> !local_grant) else $error("grant while locked");
   a_grant_free: assert property ($past(rstn) && $past(local_req) && !panel_lock |-> local_grant)
      else $error("grant missing");
   a_freq_legal: assert property (mains_frequency_setting != 2'h3) else $error("bad frequency");
endmodule
bind sscmd_top sscmd_properties chk (.*);
`default_nettype wire

/* sscmd_top.v */
// System settings command handler with APB registers and measurement-done output
`timescale 1ns/1ps
`default_nettype none
`include "sscmd_map.vh"
module sscmd_top (
   // Clock and reset
   input wire sys_clk,
   input wire rstn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Measurement events from the core
   input wire meas_end,
   input wire meas_start,
   // Local panel
   input wire local_req,
   output reg local_grant,
   // Settings toward the instrument
   output reg beeper_on,
   output reg [1:0] mains_frequency_setting,
   output reg panel_lock,
   output reg hdr_on,
   output reg term_code,
   output reg measure_done_strobe_n,
   output reg irq
);
   reg [5:0] ctrl_r;
   reg [6:0] pw_r;
   reg term_r;
   reg [23:0] date_r;
   reg [2:0] ist_r;
   reg [2:0] ien_r;
   reg [2:0] ev_r;
   reg [14:0] ms_cnt_r;
   reg [6:0] ms_left_r;
   reg eom_act_r;
   reg [31:0] rd_nxt;
   reg err_nxt;
   wire date_ok;
   wire wr_acc;
   wire rd_acc;
   wire [1:0] lf_w;
   wire pulse_rel;

   // Each transfer is answered with one wait state, in its second access cycle
   assign wr_acc = psel && penable && pwrite && !pready;
   assign rd_acc = psel && penable && !pwrite && !pready;
   assign lf_w = pwdata[`SSCMD_F_LFRQ_HI:`SSCMD_F_LFRQ_LO];
   // pulse ends on the last millisecond tick, unless a new end restarts it
   assign pulse_rel = eom_act_r && ctrl_r[`SSCMD_F_MODE] && !meas_end &&
                      (ms_cnt_r == `SSCMD_MS_CYC - 1) && (ms_left_r <= 7'h01);

   sscmd_date_chk u_date (
      .year_bcd(pwdata[23:16]),
      .month_bcd(pwdata[15:8]),
      .day_bcd(pwdata[7:0]),
      .date_ok(date_ok)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read mux and error decode
   always @* begin
      rd_nxt = 32'h0000_0000;
      err_nxt = 1'b0;
      case (paddr)
         `SSCMD_CTRL: rd_nxt = {26'h000_0000, ctrl_r};
         `SSCMD_EOMW: rd_nxt = {25'h000_0000, pw_r};
         `SSCMD_TERM: rd_nxt = {31'h0000_0000, term_r};
         `SSCMD_DATE: rd_nxt = {8'h00, date_r};
         `SSCMD_CMD: rd_nxt = 32'h0000_0000;
         // serial terminator fixed, parallel code beside it
         `SSCMD_STAT: rd_nxt = {8'h00, `SSCMD_CR, `SSCMD_LF, 6'h00, eom_act_r, term_r};
         `SSCMD_IRQ_ST: rd_nxt = {29'h0000_0000, ist_r};
         `SSCMD_IRQ_EN: rd_nxt = {29'h0000_0000, ien_r};
         `SSCMD_IRQ_CLR: rd_nxt = 32'h0000_0000;
         `SSCMD_STATE: rd_nxt = {25'h000_0000, ms_left_r};
         default: err_nxt = 1'b1;
      endcase
      if (pwrite) begin
         case (paddr)
            `SSCMD_CTRL: err_nxt = (lf_w == 2'h3);
            `SSCMD_EOMW: err_nxt = (pwdata[6:0] < `SSCMD_PW_MIN) || (pwdata[6:0] > `SSCMD_PW_MAX) ||
                                   (pwdata[31:7] != 25'h000_0000);
            `SSCMD_DATE: err_nxt = !date_ok;
            `SSCMD_STAT: err_nxt = 1'b1;
            `SSCMD_IRQ_ST: err_nxt = 1'b1;
            `SSCMD_STATE: err_nxt = 1'b1;
            default: err_nxt = err_nxt;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer
   always @(posedge sys_clk) begin
      if (!rstn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && err_nxt;
         prdata <= rd_acc ? rd_nxt : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Settings registers
   always @(posedge sys_clk) begin
      if (!rstn) begin
         ctrl_r <= `SSCMD_CTRL_RST;
         pw_r <= `SSCMD_EOMW_RST;
         term_r <= 1'b0;
         date_r <= `SSCMD_DATE_RST;
         ien_r <= 3'h0;
         ev_r <= 3'h0;
      end else begin
         ev_r <= 3'h0;
         if (wr_acc && !err_nxt) begin
            case (paddr)
               `SSCMD_CTRL: ctrl_r <= pwdata[5:0];
               `SSCMD_EOMW: pw_r <= pwdata[6:0];
               `SSCMD_TERM: term_r <= pwdata[0];
               `SSCMD_DATE: date_r <= pwdata[23:0];
               `SSCMD_CMD: begin
                  if (pwdata[`SSCMD_C_RST]) begin
                     ctrl_r[`SSCMD_F_HDR] <= 1'b0;
                  end
               end
               `SSCMD_IRQ_EN: ien_r <= pwdata[2:0];
               default: ctrl_r <= ctrl_r;
            endcase
         end
         if (wr_acc && err_nxt) begin
            ev_r[`SSCMD_I_ERR] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Measurement-done strobe
   always @(posedge sys_clk) begin
      if (!rstn) begin
         eom_act_r <= 1'b0;
         ms_cnt_r <= 15'h0000;
         ms_left_r <= 7'h00;
      end else if (meas_end) begin
         eom_act_r <= 1'b1;
         ms_cnt_r <= 15'h0000;
         ms_left_r <= pw_r;
      end else if (eom_act_r) begin
         if (!ctrl_r[`SSCMD_F_MODE]) begin
            if (meas_start) begin
               eom_act_r <= 1'b0;
            end
         end else if (ms_cnt_r == `SSCMD_MS_CYC - 1) begin
            ms_cnt_r <= 15'h0000;
            if (ms_left_r <= 7'h01) begin
               eom_act_r <= 1'b0;
               ms_left_r <= 7'h00;
            end else begin
               ms_left_r <= ms_left_r - 7'h01;
            end
         end else begin
            ms_cnt_r <= ms_cnt_r + 15'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts and outputs
   always @(posedge sys_clk) begin
      if (!rstn) begin
         ist_r <= 3'h0;
         irq <= 1'b0;
         beeper_on <= 1'b0;
         mains_frequency_setting <= `SSCMD_LF_AUTO;
         panel_lock <= 1'b0;
         hdr_on <= 1'b0;
         term_code <= 1'b0;
         measure_done_strobe_n <= 1'b1;
         local_grant <= 1'b0;
      end else begin
         // Set wins over a clear in the same cycle
         ist_r <= (ist_r & ~((wr_acc && paddr == `SSCMD_IRQ_CLR) ? pwdata[2:0] : 3'h0)) |
                  ev_r | {pulse_rel, meas_end, 1'b0};
         irq <= |(ist_r & ien_r);
         beeper_on <= ctrl_r[`SSCMD_F_BEEP];
         mains_frequency_setting <= ctrl_r[`SSCMD_F_LFRQ_HI:`SSCMD_F_LFRQ_LO];
         panel_lock <= ctrl_r[`SSCMD_F_LOCK];
         hdr_on <= ctrl_r[`SSCMD_F_HDR];
         term_code <= term_r;
         measure_done_strobe_n <= !eom_act_r;
         local_grant <= local_req && !ctrl_r[`SSCMD_F_LOCK];
      end
   end
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking testbench for the settings handler
`timescale 1ns/1ps
`default_nettype none
`include "sscmd_map.vh"
module testbench;
   logic sys_clk = 1'b0, rstn = 1'b0, meas_end = 1'b0, meas_start = 1'b0, local_req = 1'b0;
   wire psel, penable, pwrite, pready, pslverr, local_grant, beeper_on, panel_lock, hdr_on;
   wire term_code, measure_done_strobe_n, irq;
   wire [11:0] paddr;
   wire [31:0] pwdata, prdata;
   wire [1:0] mains_frequency_setting;
   int num_errors = 0, checks_done = 0, i, n;
   integer seed = 32'h33d4_5dff;
   logic [31:0] v;
   logic [33:0] x;
   logic [33:0] expq[$];
   sscmd_top dut (.*);
   sscmd_host host (.*);
   initial forever #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) local_req <= 1'($random(seed));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task test_done;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Read data is expected only on a read that was not refused
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
      expq.push_back({!w, e, d});
      host.xfer(w, a, d);
   endtask
   task ev(input logic s);
      @(posedge sys_clk);
      if (s) meas_start <= 1'b1; else meas_end <= 1'b1;
      @(posedge sys_clk);
      meas_start <= 1'b0;
      meas_end <= 1'b0;
   endtask
   always @(posedge sys_clk) if (pready === 1'b1) begin
      if (expq.size() == 0) chk(32'h1, 32'h0);
      else begin
         x = expq.pop_front();
         chk({31'h0, pslverr}, {31'h0, x[32]});
         if (x[33] && !x[32]) chk(prdata, x[31:0]);
      end
   end
   initial begin
      #(40 * 60000);
      num_errors++;
      test_done;
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      bus(0, `SSCMD_CTRL, 0, 0);
      bus(0, `SSCMD_EOMW, 1, 0);
      bus(0, `SSCMD_TERM, 0, 0);
      bus(0, `SSCMD_STAT, 32'h000D_0A00, 0);
      bus(0, `SSCMD_DATE, 32'h0000_0101, 0);
      for (i = 0; i < 3; i++) begin
         v = ($random(seed) & 32'h0000_0011) | (i << 1) | (i << 3);
         bus(1, `SSCMD_CTRL, v, 0);
         bus(0, `SSCMD_CTRL, v, 0);
         repeat (2) @(posedge sys_clk);
         chk({beeper_on, mains_frequency_setting, panel_lock, hdr_on}, {v[0], v[2:1], v[3], v[4]});
      end
      bus(1, `SSCMD_CMD, 1, 0);
      repeat (3) @(posedge sys_clk);
      chk(hdr_on, 0);
      bus(1, `SSCMD_CTRL, 6, 1);
      bus(0, `SSCMD_CTRL, v & 32'h0000_000F, 0);
      $display("settings done");
      bus(1, `SSCMD_STAT, 0, 1);
      bus(0, 12'h028, 0, 1);
      bus(1, `SSCMD_EOMW, 0, 1);
      bus(1, `SSCMD_EOMW, 101, 1);
      bus(1, `SSCMD_EOMW, 100, 0);
      bus(0, `SSCMD_EOMW, 100, 0);
      bus(1, `SSCMD_EOMW, 1, 0);
      bus(1, `SSCMD_DATE, 32'h0009_1203, 0);
      bus(1, `SSCMD_DATE, 32'h0009_0631, 1);
      bus(1, `SSCMD_DATE, 32'h0009_1301, 1);
      bus(0, `SSCMD_DATE, 32'h0009_1203, 0);
      bus(1, `SSCMD_DATE, 32'h0024_0229, 0);
      bus(1, `SSCMD_TERM, 1, 0);
      bus(0, `SSCMD_STAT, 32'h000D_0A01, 0);
      chk(term_code, 1);
      $display("refusals done");
      bus(0, `SSCMD_IRQ_ST, 1, 0);
      bus(1, `SSCMD_IRQ_EN, 1, 0);
      repeat (2) @(posedge sys_clk);
      chk(irq, 1);
      bus(1, `SSCMD_IRQ_CLR, 1, 0);
      repeat (2) @(posedge sys_clk);
      chk(irq, 0);
      ev(0);
      repeat (60) @(posedge sys_clk);
      chk({irq, measure_done_strobe_n}, 0);
      ev(1);
      repeat (3) @(posedge sys_clk);
      chk(measure_done_strobe_n, 1);
      bus(1, `SSCMD_IRQ_EN, 2, 0);
      repeat (2) @(posedge sys_clk);
      chk(irq, 1);
      $display("hold mode done");
      // Second end in mid-pulse must restart the timer
      bus(1, `SSCMD_CTRL, 32'h0000_0020, 0);
      ev(0);
      // Strobe falls on the edge after the one that samples the end pulse
      repeat (2) @(posedge sys_clk);
      n = 0;
      while (measure_done_strobe_n !== 1'b1 && n < 60000) begin
         @(posedge sys_clk);
         n++;
         meas_end <= (n == 10000);
      end
      chk(n >= 10000 + `SSCMD_MS_CYC - 5 && n <= 10000 + `SSCMD_MS_CYC + 8, 1);
      bus(0, `SSCMD_IRQ_ST, 32'h0000_0006, 0);
      $display("pulse mode done");
      test_done;
   end
endmodule
`default_nettype wire
